// [mbg_pkg.sv]
// Package of constants and types for the memory and register access guard
`default_nettype none
package mbg_pkg;
    localparam int MBG_AW       = 16;
    localparam int MBG_SEG_N    = 64;
    localparam int MBG_SEG_IW   = 6;
    localparam int MBG_PA_W     = 17;

    // Memory selects
    localparam logic [1:0] MBG_MEM_ROM  = 2'h0;
    localparam logic [1:0] MBG_MEM_EE   = 2'h1;
    localparam logic [1:0] MBG_MEM_RAM  = 2'h2;
    localparam logic [1:0] MBG_MEM_NONE = 2'h3;

    // Physical partition bounds (partition sizes are fixed by configuration)
    localparam logic [MBG_PA_W-1:0] MBG_ROM_BASE    = 17'h00000;
    localparam logic [MBG_PA_W-1:0] MBG_ROM_TEST_END = 17'h01fff;
    localparam logic [MBG_PA_W-1:0] MBG_ROM_END     = 17'h0ffff;
    localparam logic [MBG_PA_W-1:0] MBG_EE_BASE     = 17'h10000;
    localparam logic [MBG_PA_W-1:0] MBG_EE_CFG_END  = 17'h107ff;
    localparam logic [MBG_PA_W-1:0] MBG_EE_SECROW_LO = 17'h10800;
    localparam logic [MBG_PA_W-1:0] MBG_EE_SECROW_HI = 17'h1083f;
    localparam logic [MBG_PA_W-1:0] MBG_EE_END      = 17'h17fff;
    localparam logic [MBG_PA_W-1:0] MBG_RAM_BASE    = 17'h18000;
    localparam logic [MBG_PA_W-1:0] MBG_RAM_END     = 17'h1ffff;

    // Access classes
    localparam logic [1:0] MBG_OP_READ  = 2'h0;
    localparam logic [1:0] MBG_OP_WRITE = 2'h1;
    localparam logic [1:0] MBG_OP_EXEC  = 2'h2;

    // Register groups
    localparam logic [2:0] MBG_GRP_SEGCFG = 3'h0;
    localparam logic [2:0] MBG_GRP_SYSMGT = 3'h1;
    localparam logic [2:0] MBG_GRP_TEST   = 3'h2;
    localparam logic [2:0] MBG_GRP_HWCOMP = 3'h3;
    localparam logic [2:0] MBG_GRP_CPU    = 3'h4;

    // Segmentation configuration register offsets and reset
    localparam logic [7:0]  MBG_REG_TBL_LO   = 8'h00;
    localparam logic [7:0]  MBG_REG_TBL_HI   = 8'h01;
    localparam logic [7:0]  MBG_REG_VIOL     = 8'h02;
    localparam logic [15:0] MBG_TBL_RST      = 16'h0000;

    // Mode encoding from status bits: {int1, int0, ps[4]}
    localparam logic [1:0] MBG_INT_BOOT = 2'h3;
    localparam logic [1:0] MBG_INT_TEST = 2'h2;
    localparam logic [1:0] MBG_INT_CL   = 2'h1;
    localparam int         MBG_PS_SYS_BIT = 4;

    // Segment entry: rights, bounds, offset, hardware register rights
    localparam int MBG_ENT_W = 3 + 2 * MBG_AW + MBG_PA_W + 2;

    typedef enum logic [2:0] {
        MBG_MODE_BOOT, MBG_MODE_TEST, MBG_MODE_CL, MBG_MODE_SYS, MBG_MODE_USER
    } mbg_mode_e;
endpackage
`default_nettype wire

// [mbg_guard.sv]
// Access guard: mode derivation, segment translation, memory and register checks
//
// Overview of operation
// R01: Mode comes from status high register and two internal bits each instruction.
// R02: Segment entry holds read/write/execute rights, first/last address, relocation offset.
// R03: Segment entry also holds rights to hardware component registers.
// R04: Entry with no rights at all is disabled and matches nothing.
// R05: Any number of segments up to 64 may be defined.
// R06: CPU addresses are virtual and translated before reaching memory. The code relocates them in user mode only; privileged modes use the flat map.
// R07: Permission is checked before memory is accessed; denied never reaches memory.
// R08: Every register access is granted or denied by mode and register identity.
// R09: User mode hardware register rights come from executing code's segment.
// R10: Denied register read returns zero; denied write is dropped.
// R11: Boot: test ROM read/exec, config EEPROM all, RAM read/write. The privileged flat map of the 16-bit address reaches ROM only.
// R12: Test: whole ROM read/exec, whole EEPROM all, RAM read/write. The privileged flat map of the 16-bit address reaches ROM only.
// R13: Contactless: test ROM read/exec, config EEPROM all, no RAM access. The privileged flat map of the 16-bit address reaches no EEPROM.
// R14: System: application ROM read/exec, application EEPROM all, RAM read/write. The privileged flat 16-bit map reaches ROM only.
// R15: User memory access limited to rights of matching segment entry.
// R16: Boot and contactless modes may also read the security row. The privileged flat map of the 16-bit address never reaches it.
// R17: Coprocessor reads EEPROM and reads/writes its own RAM regardless of mode.
// R18: Memory accesses classed read/write/execute, register accesses read/write.
// R19: Segment table address registers reset to zero, disabling all segments.
// R20: Segmentation configuration registers refused outside system mode.
// R21: Refused memory access is blocked and raises a held violation flag.
// R22: Address outside any enabled segment or its bounds is denied.
//
// The register addresses and the strobed register port were decided locally.
`default_nettype none
module mbg_guard
    import mbg_pkg::*;
#(
    parameter int SEG_N = MBG_SEG_N
) (
    input  wire logic                  ref_clk,
    input  wire logic                  rst_b,
    // Mode sources
    input  wire logic [7:0]            program_status_high,
    input  wire logic [1:0]            mode_int_bits,
    // Segment table as fetched by the table walker
    input  wire logic [MBG_ENT_W-1:0]  seg_entry [SEG_N],
    input  wire logic [MBG_SEG_IW-1:0] exec_seg,
    // CPU memory request
    input  wire logic                  mem_req,
    input  wire logic [1:0]            mem_op,
    input  wire logic [MBG_AW-1:0]     mem_vaddr,
    // Coprocessor memory request
    input  wire logic                  cop_req,
    input  wire logic                  cop_wr,
    input  wire logic [MBG_PA_W-1:0]   cop_paddr,
    input  wire logic [MBG_PA_W-1:0]   cop_ram_lo,
    input  wire logic [MBG_PA_W-1:0]   cop_ram_hi,
    // Memory side
    output logic                       phys_req,
    output logic                       phys_wr,
    output logic [MBG_PA_W-1:0]        phys_addr,
    output logic [1:0]                 phys_mem,
    output logic                       cop_grant,
    output logic                       viol_flag,
    input  wire logic                  viol_ack,
    // CPU register port
    input  wire logic [7:0]            reg_addr,
    input  wire logic [2:0]            reg_group,
    input  wire logic [7:0]            reg_wdata,
    input  wire logic                  reg_wr,
    input  wire logic                  reg_rd,
    output logic [7:0]                 reg_rdata,
    // Register write passed to the addressed register, or dropped
    output logic                       sfr_wr,
    output logic [7:0]                 sfr_addr,
    output logic [7:0]                 sfr_wdata,
    input  wire logic [7:0]            sfr_rdata,
    output logic [15:0]                seg_table_addr,
    output logic [2:0]                 cur_mode
);
    typedef struct packed {
        logic                 phys_req;
        logic                 phys_wr;
        logic [MBG_PA_W-1:0]  phys_addr;
        logic [1:0]           phys_mem;
        logic                 cop_grant;
        logic                 viol;
        logic [7:0]           rdata;
        logic                 sfr_wr;
        logic [7:0]           sfr_addr;
        logic [7:0]           sfr_wdata;
        logic [15:0]          tbl;
        mbg_mode_e            mode;
    } mbg_state_s;

    mbg_state_s s;
    mbg_state_s next_s;

    mbg_mode_e mode;
    logic      seg_hit;
    logic [2:0] seg_rights;
    logic [1:0] seg_hw;
    logic [MBG_PA_W-1:0] seg_paddr;

    // Mode decode, combinational so it tracks each instruction
    always_comb begin
        case (mode_int_bits) // R01
            MBG_INT_BOOT: mode = MBG_MODE_BOOT;
            MBG_INT_TEST: mode = MBG_MODE_TEST;
            MBG_INT_CL:   mode = MBG_MODE_CL;
            default:      mode = program_status_high[MBG_PS_SYS_BIT] ? MBG_MODE_SYS
                                                                     : MBG_MODE_USER;
        endcase
    end

    // Segment search; lowest matching entry wins
    always_comb begin
        logic [2:0]          r;
        logic [MBG_AW-1:0]   lo;
        logic [MBG_AW-1:0]   hi;
        logic [MBG_PA_W-1:0] off;
        r = 3'h0;
        lo = '0;
        hi = '0;
        off = '0;
        seg_hit = 1'b0;
        seg_rights = 3'h0;
        seg_paddr = '0;
        for (int i = SEG_N - 1; i >= 0; i--) begin // R05
            {r, lo, hi, off} = seg_entry[i][MBG_ENT_W-1:2]; // R02
            if ((r != 3'h0 || seg_entry[i][1:0] != 2'h0)
                && mem_vaddr >= lo && mem_vaddr <= hi) begin // R04 R22
                seg_hit = 1'b1;
                seg_rights = r;
                seg_paddr = MBG_PA_W'({1'b0, mem_vaddr} + off); // R06
            end
        end
        seg_hw = seg_entry[exec_seg][1:0]; // R03 R09
    end

    // Region classification of a physical address
    function automatic logic [1:0] mbg_region(input logic [MBG_PA_W-1:0] a);
        if (a <= MBG_ROM_END)
            return MBG_MEM_ROM;
        else if (a <= MBG_EE_END)
            return MBG_MEM_EE;
        else
            return MBG_MEM_RAM;
    endfunction

    logic [MBG_PA_W-1:0] pa;
    logic                mem_ok;
    logic [1:0]          reg_ok;

    always_comb begin
        logic [1:0] rg;
        logic       t_rom;
        logic       c_ee;
        logic       sec;
        logic       rx;
        logic       rwx;
        logic       rw;
        rg = 2'h0;
        t_rom = 1'b0;
        c_ee = 1'b0;
        sec = 1'b0;
        rx = 1'b0;
        rwx = 1'b0;
        rw = 1'b0;
        // Privileged modes use a flat map; user mode is relocated
        pa = (mode == MBG_MODE_USER) ? seg_paddr : MBG_PA_W'(mem_vaddr);
        rg = mbg_region(pa);
        t_rom = pa <= MBG_ROM_TEST_END;
        c_ee = pa >= MBG_EE_BASE && pa <= MBG_EE_CFG_END;
        sec = pa >= MBG_EE_SECROW_LO && pa <= MBG_EE_SECROW_HI;
        rx = mem_op != MBG_OP_WRITE; // R18
        rwx = 1'b1;
        rw = mem_op != MBG_OP_EXEC;
        case (mode)
            MBG_MODE_BOOT: mem_ok = (rg == MBG_MEM_ROM && t_rom && rx) // R11
                                  || (c_ee && rwx) || (rg == MBG_MEM_RAM && rw)
                                  || (sec && mem_op == MBG_OP_READ); // R16
            MBG_MODE_TEST: mem_ok = (rg == MBG_MEM_ROM && rx) || rg == MBG_MEM_EE // R12
                                  || (rg == MBG_MEM_RAM && rw);
            MBG_MODE_CL:   mem_ok = (rg == MBG_MEM_ROM && t_rom && rx) || c_ee // R13
                                  || (sec && mem_op == MBG_OP_READ); // R16
            MBG_MODE_SYS:  mem_ok = (rg == MBG_MEM_ROM && !t_rom && rx) // R14
                                  || (rg == MBG_MEM_EE && !c_ee) || (rg == MBG_MEM_RAM && rw);
            MBG_MODE_USER: mem_ok = seg_hit && seg_rights[mem_op] && !t_rom && !c_ee // R15 R22
                                  && !(rg == MBG_MEM_RAM && mem_op == MBG_OP_EXEC);
            default:       mem_ok = 1'b0;
        endcase
        // Bit 0 read, bit 1 write
        case (reg_group) // R08
            MBG_GRP_CPU:    reg_ok = 2'h3;
            MBG_GRP_SEGCFG: reg_ok = (mode == MBG_MODE_SYS) ? 2'h3 : 2'h0; // R20
            MBG_GRP_HWCOMP: reg_ok = (mode == MBG_MODE_USER) ? seg_hw : 2'h3; // R09
            MBG_GRP_SYSMGT: reg_ok = (mode == MBG_MODE_BOOT || mode == MBG_MODE_TEST
                                      || mode == MBG_MODE_SYS) ? 2'h3 : 2'h0;
            MBG_GRP_TEST:   reg_ok = (mode == MBG_MODE_BOOT || mode == MBG_MODE_TEST)
                                     ? 2'h3 : 2'h0;
            default:        reg_ok = 2'h0;
        endcase
    end

    logic cop_ok;
    assign cop_ok = (mbg_region(cop_paddr) == MBG_MEM_EE && !cop_wr)
                 || (cop_paddr >= cop_ram_lo && cop_paddr <= cop_ram_hi); // R17

    always_comb begin
        next_s = s;
        next_s.mode = mode;
        next_s.phys_req = mem_req && mem_ok; // R07 R21
        next_s.phys_wr = mem_req && mem_ok && mem_op == MBG_OP_WRITE;
        next_s.phys_addr = pa;
        next_s.phys_mem = (mem_req && mem_ok) ? mbg_region(pa) : MBG_MEM_NONE;
        next_s.cop_grant = cop_req && cop_ok;
        if (viol_ack)
            next_s.viol = 1'b0;
        if (mem_req && !mem_ok)
            next_s.viol = 1'b1; // R21
        next_s.sfr_wr = reg_wr && reg_ok[1]; // R10
        next_s.sfr_addr = reg_addr;
        next_s.sfr_wdata = reg_wdata;
        if (reg_wr && reg_ok[1] && reg_group == MBG_GRP_SEGCFG) begin
            if (reg_addr == MBG_REG_TBL_LO)
                next_s.tbl[7:0] = reg_wdata;
            if (reg_addr == MBG_REG_TBL_HI)
                next_s.tbl[15:8] = reg_wdata;
        end
        next_s.rdata = 8'h00;
        if (reg_rd && reg_ok[0]) begin // R10
            if (reg_group == MBG_GRP_SEGCFG && reg_addr == MBG_REG_TBL_LO)
                next_s.rdata = s.tbl[7:0];
            else if (reg_group == MBG_GRP_SEGCFG && reg_addr == MBG_REG_TBL_HI)
                next_s.rdata = s.tbl[15:8];
            else if (reg_group == MBG_GRP_SEGCFG && reg_addr == MBG_REG_VIOL)
                next_s.rdata = {7'h00, s.viol};
            else
                next_s.rdata = sfr_rdata;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            s <= '0;
            s.tbl <= MBG_TBL_RST; // R19
            s.mode <= MBG_MODE_BOOT;
            s.phys_mem <= MBG_MEM_NONE;
        end else begin
            s <= next_s;
        end
    end

    assign phys_req = s.phys_req;
    assign phys_wr = s.phys_wr;
    assign phys_addr = s.phys_addr;
    assign phys_mem = s.phys_mem;
    assign cop_grant = s.cop_grant;
    assign viol_flag = s.viol;
    assign reg_rdata = s.rdata;
    assign sfr_wr = s.sfr_wr;
    assign sfr_addr = s.sfr_addr;
    assign sfr_wdata = s.sfr_wdata;
    assign seg_table_addr = s.tbl;
    assign cur_mode = s.mode;

    deny_no_mem_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // R07
        mem_req && !mem_ok |=> !phys_req && phys_mem == MBG_MEM_NONE)
        else $error("denied access reached memory");
    viol_set_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // R21
        mem_req && !mem_ok |=> viol_flag)
        else $error("violation flag not set");
    viol_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // R21
        viol_flag && !viol_ack && !(mem_req && !mem_ok) |=> viol_flag)
        else $error("violation flag dropped");
    rd_zero_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // R10
        reg_rd && !reg_ok[0] |=> reg_rdata == 8'h00)
        else $error("denied read returned data");
    wr_drop_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // R10
        reg_wr && !reg_ok[1] |=> !sfr_wr)
        else $error("denied write passed");
    segcfg_sys_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // R20
        reg_wr && reg_group == MBG_GRP_SEGCFG && mode != MBG_MODE_SYS
        |=> $stable(seg_table_addr))
        else $error("table pointer changed outside system mode");
    cl_ram_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // R13
        mem_req && mode == MBG_MODE_CL && mbg_region(pa) == MBG_MEM_RAM |=> !phys_req)
        else $error("contactless mode reached RAM");
    user_miss_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // R22
        mem_req && mode == MBG_MODE_USER && !seg_hit |=> !phys_req ##1 1'b1)
        else $error("unmapped user access passed");
    mode_trk_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // R01
        mode_int_bits == MBG_INT_BOOT |=> cur_mode == MBG_MODE_BOOT)
        else $error("mode not tracked");
    mode_cl_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // R01
        mode_int_bits == MBG_INT_CL |=> cur_mode == MBG_MODE_CL)
        else $error("contactless mode not tracked");
    mode_user_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // R01
        !(|mode_int_bits) && !program_status_high[MBG_PS_SYS_BIT]
        |=> cur_mode == MBG_MODE_USER)
        else $error("user mode not tracked");
    cop_ee_rd_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // R17
        cop_req && !cop_wr && mbg_region(cop_paddr) == MBG_MEM_EE |=> cop_grant)
        else $error("coprocessor read of EEPROM refused");
    user_rights_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // R15
        mem_req && mode == MBG_MODE_USER && seg_hit && !seg_rights[mem_op] |=> !phys_req)
        else $error("user access beyond segment rights passed");
    user_ram_x_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // R15
        mem_req && mode == MBG_MODE_USER && mem_op == MBG_OP_EXEC
        && mbg_region(pa) == MBG_MEM_RAM |=> !phys_req)
        else $error("user execute from RAM passed");
    sys_test_rom_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // R14
        mem_req && mode == MBG_MODE_SYS && pa <= MBG_ROM_TEST_END |=> !phys_req)
        else $error("system mode reached test ROM");
endmodule
`default_nettype wire

// [mbg_sfr_model.sv]
// Register file standing behind the guard's register port
`default_nettype none
module mbg_sfr_model (
    input  wire logic       ref_clk,
    input  wire logic [7:0] reg_addr,
    input  wire logic       sfr_wr,
    input  wire logic [7:0] sfr_addr,
    input  wire logic [7:0] sfr_wdata,
    output logic      [7:0] sfr_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [256];
    // Distinct start pattern so a dropped write shows on read back
    initial begin
        for (int i = 0; i < 256; i++) begin
            mem[i] = 8'(i) ^ 8'h5a;
        end
    end
    // Only writes the guard passes on ever land
    always @(posedge ref_clk) begin
        if (sfr_wr) begin
            mem[sfr_addr] <= sfr_wdata;
        end
    end
    assign sfr_rdata = mem[reg_addr];
endmodule
`default_nettype wire

// [test_mode_based_memory_sfr_access_guard.sv]
// Self-checking bench for the memory and register access guard
`default_nettype none
module test_mode_based_memory_sfr_access_guard
    import mbg_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic                  ref_clk, rst_b, mem_req, cop_req, cop_wr, viol_ack, reg_wr, reg_rd;
    logic                  phys_req, phys_wr, cop_grant, viol_flag, sfr_wr;
    logic [7:0]            program_status_high, reg_addr, reg_wdata, sfr_rdata, reg_rdata, d;
    logic [7:0]            sfr_addr, sfr_wdata;
    logic [1:0]            mode_int_bits, mem_op, phys_mem, op;
    logic [2:0]            reg_group, cur_mode;
    logic [15:0]           mem_vaddr, seg_table_addr;
    logic [MBG_SEG_IW-1:0] exec_seg;
    logic [MBG_PA_W-1:0]   cop_paddr, cop_ram_lo, cop_ram_hi, phys_addr;
    logic [MBG_ENT_W-1:0]  seg_entry [MBG_SEG_N];
    int                    n_fail, checks;
    // Rows of {mode bits, access class, allowed, address}
    localparam logic [20:0] PRIV [13] = '{
        {2'h3, 2'h0, 1'b1, 16'h1000}, {2'h3, 2'h2, 1'b1, 16'h1fff}, {2'h3, 2'h1, 1'b0, 16'h1000},
        {2'h3, 2'h0, 1'b0, 16'h2000}, {2'h2, 2'h0, 1'b1, 16'h2000}, {2'h2, 2'h2, 1'b1, 16'hffff},
        {2'h2, 2'h1, 1'b0, 16'h0000}, {2'h1, 2'h0, 1'b1, 16'h0000}, {2'h1, 2'h0, 1'b0, 16'h4000},
        {2'h0, 2'h0, 1'b1, 16'h2000}, {2'h0, 2'h2, 1'b1, 16'h8000}, {2'h0, 2'h0, 1'b0, 16'h1000},
        {2'h0, 2'h1, 1'b0, 16'h3000}};
    localparam logic [17:0] CORN [8] = '{{2'h2, 16'h0010}, {2'h1, 16'h00ff}, {2'h0, 16'h0150},
        {2'h0, 16'h03a0}, {2'h0, 16'h0200}, {2'h1, 16'h0250}, {2'h1, 16'h0300}, {2'h0, 16'h0300}};
    // Rows of {write, physical address, granted}
    localparam logic [18:0] COPT [7] = '{{1'b0, 17'h10400, 1'b1}, {1'b1, 17'h10400, 1'b0},
        {1'b1, 17'h1c010, 1'b1}, {1'b0, 17'h1c0ff, 1'b1}, {1'b1, 17'h1c100, 1'b0},
        {1'b0, 17'h18000, 1'b0}, {1'b0, 17'h00100, 1'b0}};

    mbg_guard u_mbg_guard (.ref_clk, .rst_b, .program_status_high, .mode_int_bits, .seg_entry,
        .exec_seg, .mem_req, .mem_op, .mem_vaddr, .cop_req, .cop_wr, .cop_paddr, .cop_ram_lo,
        .cop_ram_hi, .phys_req, .phys_wr, .phys_addr, .phys_mem, .cop_grant, .viol_flag,
        .viol_ack, .reg_addr, .reg_group, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .sfr_wr,
        .sfr_addr, .sfr_wdata, .sfr_rdata, .seg_table_addr, .cur_mode);
    mbg_sfr_model u_mbg_sfr_model (.ref_clk, .reg_addr, .sfr_wr, .sfr_addr, .sfr_wdata,
        .sfr_rdata);

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    function automatic logic [2:0] mode_exp(input logic [1:0] ib, input logic [7:0] ps);
        case (ib)
            MBG_INT_BOOT: return MBG_MODE_BOOT;
            MBG_INT_TEST: return MBG_MODE_TEST;
            MBG_INT_CL:   return MBG_MODE_CL;
            default:      return ps[MBG_PS_SYS_BIT] ? MBG_MODE_SYS : MBG_MODE_USER;
        endcase
    endfunction
    // Lowest enabled segment holding the address decides; returns {ok, memory, address}
    function automatic logic [19:0] user_exp(input logic [1:0] op, input logic [15:0] va);
        logic [MBG_ENT_W-1:0] e;
        logic [16:0]          pa;
        for (int i = 0; i < MBG_SEG_N; i++) begin
            e = seg_entry[i];
            if ((e[53:51] != 3'h0 || e[1:0] != 2'h0) && va >= e[50:35] && va <= e[34:19]) begin
                pa = 17'(va) + e[18:2];
                return {e[51 + op] && !(op == MBG_OP_EXEC && pa >= MBG_RAM_BASE),
                    pa >= MBG_RAM_BASE ? MBG_MEM_RAM : pa >= MBG_EE_BASE ? MBG_MEM_EE : MBG_MEM_ROM,
                    pa};
            end
        end
        return {1'b0, MBG_MEM_NONE, 17'h0};
    endfunction
    task automatic mode(input logic [1:0] ib, input logic [7:0] ps);
        @(posedge ref_clk);
        mode_int_bits <= ib;
        program_status_high <= ps;
        repeat (2) @(posedge ref_clk);
    endtask
    task automatic mem(input logic [1:0] op, input logic [15:0] va, input logic [19:0] e);
        @(posedge ref_clk);
        mem_req <= 1'b1;
        mem_op <= op;
        mem_vaddr <= va;
        @(posedge ref_clk);
        mem_req <= 1'b0;
        #1;
        check("phys_req", phys_req, e[19]);
        check("viol_flag", viol_flag, !e[19]);
        if (e[19]) begin
            check("phys_target", {phys_wr, phys_mem, phys_addr}, {op == MBG_OP_WRITE, e[18:0]});
        end else begin
            repeat (2) @(posedge ref_clk);
            #1;
            check("viol_held", viol_flag, 1'b1);
            @(posedge ref_clk);
            viol_ack <= 1'b1;
            @(posedge ref_clk);
            viol_ack <= 1'b0;
            #1;
            check("viol_acked", viol_flag, 1'b0);
        end
    endtask
    task automatic cop(input logic [18:0] t);
        @(posedge ref_clk);
        cop_req <= 1'b1;
        cop_wr <= t[18];
        cop_paddr <= t[17:1];
        @(posedge ref_clk);
        cop_req <= 1'b0;
        #1;
        check("cop_grant", cop_grant, t[0]);
    endtask
    task automatic wr(input logic [2:0] g, input logic [7:0] a, input logic [7:0] v,
                      input logic pass);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_group <= g;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        #1;
        if (g != MBG_GRP_SEGCFG) begin
            check("sfr_wr", sfr_wr, pass);
        end
        if (pass && g != MBG_GRP_SEGCFG) begin
            check("sfr_write", {sfr_addr, sfr_wdata}, {a, v});
        end
    endtask
    task automatic rd(input logic [2:0] g, input logic [7:0] a, input logic [7:0] exp);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_group <= g;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        check("reg_rdata", reg_rdata, exp);
    endtask

    initial begin
        forever #12.5 ref_clk = ~ref_clk;
    end
    initial begin
        #200000;
        n_fail++;
        final_report();
    end
    initial begin
        ref_clk = 1'b0;
        rst_b = 1'b0;
        {mem_req, cop_req, cop_wr, viol_ack, reg_wr, reg_rd, mem_op, reg_group, exec_seg} = '0;
        {mem_vaddr, reg_addr, reg_wdata, cop_paddr, mode_int_bits, program_status_high} = '0;
        cop_ram_lo = 17'h1c000;
        cop_ram_hi = 17'h1c0ff;
        // Unused entries stay empty
        foreach (seg_entry[i]) seg_entry[i] = '0;
        seg_entry[0] = {3'b111, 16'h0000, 16'h00ff, 17'h18000, 2'b11};
        seg_entry[2] = {3'b101, 16'h0200, 16'h02ff, 17'h02000, 2'b00};
        seg_entry[3] = {3'b110, 16'h0300, 16'h037f, 17'h10900, 2'b00};
        // Register rights only: still enabled, so it shadows entry 4
        seg_entry[1] = {3'b000, 16'h0150, 16'h015f, 17'h00000, 2'b01};
        seg_entry[4] = {3'b001, 16'h0150, 16'h015f, 17'h02000, 2'b00};
        void'($urandom(57975));
        @(posedge ref_clk);
        #1;
        check("rst_out", {phys_mem, seg_table_addr, cur_mode, viol_flag}, {2'h3, 20'h0});
        @(posedge ref_clk);
        rst_b <= 1'b1;
        $display("test reset done");
        for (int i = 0; i < 12; i++) begin
            d = (i < 4) ? 8'h10 : (i < 8) ? 8'hef : 8'($urandom);
            mode(2'(i), d);
            #1;
            check("cur_mode", cur_mode, mode_exp(2'(i), d));
        end
        $display("test modes done");
        foreach (PRIV[i]) begin
            mode(PRIV[i][20:19], 8'h10);
            mem(PRIV[i][18:17], PRIV[i][15:0], {PRIV[i][16], MBG_MEM_ROM, 1'b0, PRIV[i][15:0]});
        end
        $display("test privileged memory done");
        mode(2'h0, 8'h00);
        for (int i = 0; i < 48; i++) begin
            op = (i < 8) ? CORN[i][17:16] : 2'($urandom_range(2));
            d = 8'($urandom);
            mem(op, (i < 8) ? CORN[i][15:0] : {6'h0, op, d},
                user_exp(op, (i < 8) ? CORN[i][15:0] : {6'h0, op, d}));
        end
        $display("test user memory done");
        foreach (COPT[i]) cop(COPT[i]);
        mode(2'h1, 8'h00);
        cop(COPT[2]);
        $display("test coprocessor done");
        mode(2'h3, 8'h00);
        d = 8'($urandom);
        wr(MBG_GRP_TEST, 8'h20, d, 1'b1);
        rd(MBG_GRP_TEST, 8'h20, d);
        mode(2'h0, 8'h00);
        exec_seg <= 6'h2;
        wr(MBG_GRP_HWCOMP, 8'h30, 8'ha5, 1'b0);
        rd(MBG_GRP_HWCOMP, 8'h30, 8'h00);
        rd(MBG_GRP_TEST, 8'h20, 8'h00);
        rd(MBG_GRP_CPU, 8'h40, 8'h40 ^ 8'h5a);
        wr(MBG_GRP_SEGCFG, MBG_REG_TBL_LO, 8'h77, 1'b0);
        @(posedge ref_clk);
        exec_seg <= 6'h0;
        rd(MBG_GRP_HWCOMP, 8'h30, 8'h30 ^ 8'h5a);
        wr(MBG_GRP_HWCOMP, 8'h31, 8'h3c, 1'b1);
        mode(2'h1, 8'h00);
        wr(MBG_GRP_SEGCFG, MBG_REG_TBL_HI, 8'h12, 1'b0);
        rd(MBG_GRP_HWCOMP, 8'h31, 8'h3c);
        check("seg_table_addr", seg_table_addr, MBG_TBL_RST);
        mode(2'h0, 8'h10);
        wr(MBG_GRP_SEGCFG, MBG_REG_TBL_LO, 8'h34, 1'b1);
        wr(MBG_GRP_SEGCFG, MBG_REG_TBL_HI, 8'h12, 1'b1);
        check("seg_table_addr", seg_table_addr, 16'h1234);
        rd(MBG_GRP_SEGCFG, MBG_REG_TBL_LO, 8'h34);
        rd(MBG_GRP_TEST, 8'h20, 8'h00);
        $display("test registers done");
        @(posedge ref_clk);
        rst_b <= 1'b0;
        @(posedge ref_clk);
        #1;
        check("rst_again", {seg_table_addr, cur_mode}, {MBG_TBL_RST, 3'h0});
        @(posedge ref_clk);
        rst_b <= 1'b1;
        repeat (2) @(posedge ref_clk);
        #1;
        check("mode_after_rst", cur_mode, MBG_MODE_SYS);
        check("tbl_after_rst", seg_table_addr, MBG_TBL_RST);
        $display("test second reset done");
        final_report();
    end
endmodule
`default_nettype wire
